// ==== ddb_pkg.sv ====
/*
  Package for the demultiplexed bus sequencer: timing constants, states and
  the request/bus carrier structs.
  Assumes one core clock clk_sys; one core period is the unit t.
*/
`default_nettype none
package ddb_pkg;
   // ----------------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------------
   localparam int unsigned CLK_PERIOD_NS  = 50;
   localparam int unsigned STATE_NS       = 100;  // One bus state, 2t
   localparam int unsigned STATE_CYC      = (STATE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned DEFER_BIT_POS  = 5;    // Deferred enable in config byte one
   localparam logic [7:0]  CFG_ONE_RESET  = 8'h00; // Deferred mode off
   localparam int unsigned ADDR_W         = 20;
   localparam int unsigned DATA_W         = 16;
   localparam int unsigned REGIONS        = 6;
   localparam int unsigned WS_W           = 2;    // Programmed waits 0..3

   // ----------------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_IDLE  = 3'b000,
      ST_DEFER = 3'b001,
      ST_ADDR  = 3'b011,
      ST_DATA  = 3'b010,
      ST_WAIT  = 3'b110
   } ddb_state_t;

   typedef struct packed {
      logic              write;
      logic [2:0]        region;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic              high_byte;
      logic              fetch;
   } ddb_req_t;

   typedef struct packed {
      logic [ADDR_W-1:0]  addr;
      logic [REGIONS-1:0] region_select_n;
      logic               ale;
      logic               rd_n;
      logic               wr_n;
      logic               high_byte_enable_n;
      logic               fetch_indicator;
      logic [DATA_W-1:0]  dout;
      logic               dout_oe;
   } ddb_bus_t;
endpackage : ddb_pkg
`default_nettype wire

// ==== ddb_phase.sv ====
/*
  Divider making the half-state phase and clock_output (period 2t).
  Assumes synchronous active-high reset on clk_sys.
*/
`timescale 1ns/100ps
`default_nettype none
module ddb_phase
   import ddb_pkg::*;
(
   input  wire logic clk_sys,
   input  wire logic rst,
   output var  logic phase,
   output var  logic clock_output
);
   logic next_phase;

   // Toggle every core period; phase 1 ends a bus state
   always_comb begin
      next_phase = ~phase;
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         phase        <= 1'b0;
         clock_output <= 1'b0;
      end else begin
         phase        <= next_phase;
         clock_output <= next_phase;
      end
   end
endmodule : ddb_phase
`default_nettype wire

// ==== ddb_seq.sv ====
/*
  Demultiplexed external bus sequencer with optional deferred cycles.
  Assumes the core holds req_valid and req until req_ready; ready_pin comes
  from outside and is synchronised here. Region wait counts come from the
  region configuration of the caller.
*/
`timescale 1ns/100ps
`default_nettype none
module ddb_seq
   import ddb_pkg::*;
#(
   parameter int unsigned N_REGIONS = REGIONS
)(
   input  wire logic                         clk_sys,
   input  wire logic                         rst,
   input  wire logic [7:0]                   chip_config_byte_one,
   input  wire logic [N_REGIONS*WS_W-1:0]    bus_region_config,
   input  wire logic                         req_valid,
   input  wire ddb_req_t                     req,
   input  wire logic                         ready_pin,
   input  wire logic [DATA_W-1:0]            din,
   output var  logic                         req_ready,
   output var  logic [DATA_W-1:0]            rdata,
   output var  logic                         rdata_valid,
   output var  ddb_bus_t                     bus,
   output var  logic                         clock_output,
   output var  logic                         defer_active
);
   // Only the documented region count and a two-period state are served
   if (N_REGIONS != REGIONS || STATE_CYC != 2) begin : g_bad_params
      $error("ddb_seq: unsupported parameters");
   end

   // ----------------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------------
   function automatic logic [REGIONS-1:0] region_decode(input logic [2:0] r);
      logic [REGIONS-1:0] v;
      v = '1;
      if (r < 3'(REGIONS)) v[r] = 1'b0;
      return v;
   endfunction

   function automatic logic [WS_W-1:0] region_waits(input logic [2:0] r,
                                                   input logic [N_REGIONS*WS_W-1:0] cfg);
      logic [WS_W-1:0] w;
      w = '0;
      for (int i = 0; i < N_REGIONS; i++) begin
         if (r == 3'(i)) w = cfg[i*WS_W +: WS_W];
      end
      return w;
   endfunction

   // ----------------------------------------------------------------------
   // Clocking, pin synchroniser
   // ----------------------------------------------------------------------
   logic phase;
   logic ready_meta, ready_sync;

   ddb_phase u_phase (
      .clk_sys      (clk_sys),
      .rst          (rst),
      .phase        (phase),
      .clock_output (clock_output)
   );

   // READY is asynchronous to the core; two flops before use
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         ready_meta <= 1'b1;
         ready_sync <= 1'b1;
      end else begin
         ready_meta <= ready_pin;
         ready_sync <= ready_meta;
      end
   end

   // ----------------------------------------------------------------------
   // Sequencer
   // ----------------------------------------------------------------------
   ddb_state_t      state, next_state;
   ddb_req_t        cur, next_cur;
   logic [2:0]      last_region, next_last_region;
   logic            last_write, next_last_write;
   logic            have_last, next_have_last;
   logic [WS_W-1:0] ws_left, next_ws_left;
   logic            next_req_ready, next_rdata_valid, next_defer_active;
   logic [DATA_W-1:0] next_rdata;
   ddb_bus_t        next_bus;
   logic            defer_en, need_defer;

   assign defer_en   = chip_config_byte_one[DEFER_BIT_POS];
   // Either cause gives the same single state, never two
   assign need_defer = defer_en && have_last &&
                       ((req.region != last_region) ||
                        (req.write && !last_write));

   always_comb begin
      next_state        = state;
      next_cur          = cur;
      next_last_region  = last_region;
      next_last_write   = last_write;
      next_have_last    = have_last;
      next_ws_left      = ws_left;
      next_req_ready    = 1'b0;
      next_rdata        = rdata;
      next_rdata_valid  = 1'b0;
      next_defer_active = defer_active;
      next_bus          = bus;
      next_bus.ale      = 1'b0;
      case (state)
         ST_IDLE: begin
            if (req_valid && !req_ready && phase) begin
               next_cur = req;
               next_bus.addr               = req.addr;
               next_bus.region_select_n    = region_decode(req.region);
               next_bus.high_byte_enable_n = ~req.high_byte;
               next_bus.fetch_indicator    = req.fetch;
               next_bus.dout               = req.wdata;
               next_bus.dout_oe            = req.write;
               next_ws_left = region_waits(req.region, bus_region_config);
               if (need_defer) begin
                  next_state        = ST_DEFER;
                  next_defer_active = 1'b1;
               end else begin
                  next_state   = ST_ADDR;
                  next_bus.ale = 1'b1;
               end
            end
         end
         ST_DEFER: begin
            // Address and select held, strobes stay high for one state
            if (phase) begin
               next_state        = ST_ADDR;
               next_bus.ale      = 1'b1;
               next_defer_active = 1'b0;
            end
         end
         ST_ADDR: begin
            if (phase) begin
               next_state = ST_DATA;
               if (cur.write) next_bus.wr_n = 1'b0;
               else next_bus.rd_n = 1'b0;
            end
         end
         ST_DATA, ST_WAIT: begin
            // Deferral already spent; waits still counted here
            if (phase) begin
               if (ws_left != '0) begin
                  next_ws_left = ws_left - 1'b1;
                  next_state   = ST_WAIT;
               end else if (!ready_sync) begin
                  next_state = ST_WAIT;
               end else begin
                  next_state       = ST_IDLE;
                  next_bus.rd_n    = 1'b1;
                  next_bus.wr_n    = 1'b1;
                  next_req_ready   = 1'b1;
                  next_rdata       = din;
                  next_rdata_valid = !cur.write;
                  next_last_region = cur.region;
                  next_last_write  = cur.write;
                  next_have_last   = 1'b1;
               end
            end
         end
         default: next_state = ST_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         state        <= ST_IDLE;
         cur          <= '0;
         last_region  <= '0;
         last_write   <= 1'b0;
         have_last    <= 1'b0;
         ws_left      <= '0;
         req_ready    <= 1'b0;
         rdata        <= '0;
         rdata_valid  <= 1'b0;
         defer_active <= 1'b0;
         bus          <= '{addr: '0, region_select_n: '1, ale: 1'b0, rd_n: 1'b1,
                           wr_n: 1'b1, high_byte_enable_n: 1'b1, fetch_indicator: 1'b0,
                           dout: '0, dout_oe: 1'b0};
      end else begin
         state        <= next_state;
         cur          <= next_cur;
         last_region  <= next_last_region;
         last_write   <= next_last_write;
         have_last    <= next_have_last;
         ws_left      <= next_ws_left;
         req_ready    <= next_req_ready;
         rdata        <= next_rdata;
         rdata_valid  <= next_rdata_valid;
         defer_active <= next_defer_active;
         bus          <= next_bus;
      end
   end

   // ----------------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------------
   a_defer_off: assert property (@(posedge clk_sys) disable iff (rst)
      !defer_en |-> !defer_active) else $error("defer state while mode off");
   a_defer_len: assert property (@(posedge clk_sys) disable iff (rst)
      $rose(defer_active) |-> defer_active ##1 defer_active ##1 !defer_active)
      else $error("defer state not one state long");
   a_no_strobe_defer: assert property (@(posedge clk_sys) disable iff (rst)
      defer_active |-> bus.rd_n && bus.wr_n && !bus.ale) else $error("strobe in defer");
   a_ale_after_defer: assert property (@(posedge clk_sys) disable iff (rst)
      $fell(defer_active) |-> bus.ale) else $error("ale missing after defer");
   a_region_defer: assert property (@(posedge clk_sys) disable iff (rst)
      (state == ST_IDLE && req_valid && !req_ready && phase && defer_en && have_last
       && req.region != last_region) |=> defer_active) else $error("region change no defer");
   a_turn_defer: assert property (@(posedge clk_sys) disable iff (rst)
      (state == ST_IDLE && req_valid && !req_ready && phase && defer_en && have_last
       && req.write && !last_write) |=> defer_active) else $error("turnaround no defer");
   a_plain_cycle: assert property (@(posedge clk_sys) disable iff (rst)
      ($rose(bus.ale) && ws_left == '0 && ready_sync) |-> ##2 (!bus.rd_n || !bus.wr_n))
      else $error("strobe not at state two");
   a_ready_hold: assert property (@(posedge clk_sys) disable iff (rst)
      (state inside {ST_DATA, ST_WAIT} && phase && ws_left == '0 && !ready_sync)
      |=> state == ST_WAIT && (!bus.rd_n || !bus.wr_n)) else $error("not ready ended cycle");
   a_prog_wait: assert property (@(posedge clk_sys) disable iff (rst)
      (state inside {ST_DATA, ST_WAIT} && phase && ws_left != '0)
      |=> state == ST_WAIT && ws_left == $past(ws_left) - 1'b1) else $error("wait not counted");

   c_defer:  cover property (@(posedge clk_sys) $rose(defer_active));
   c_wait:   cover property (@(posedge clk_sys) state == ST_WAIT);
   c_read:   cover property (@(posedge clk_sys) rdata_valid);
   c_both:   cover property (@(posedge clk_sys) defer_active ##[1:20] state == ST_WAIT);
endmodule : ddb_seq
`default_nettype wire

// ==== ddb_mem_model.sv ====
/*
  Behavioural model of a slow memory on the demultiplexed bus.
  Assumes the sequencer bus struct and a stall count set by the bench.
*/
`timescale 1ns/100ps
`default_nettype none
module ddb_mem_model
   import ddb_pkg::*;
(
   input  wire logic              clk_sys,
   input  wire ddb_bus_t          bus,
   input  wire logic [7:0]        stall,
   output var  logic              ready_pin,
   output var  logic [DATA_W-1:0] din
);
   // ----------------------------------------------------------------------
   // Ready stretching and read data
   // ----------------------------------------------------------------------
   logic [7:0]        left;
   logic              strobe_d;
   logic [DATA_W-1:0] last;

   initial begin
      left = 8'h00;
      strobe_d = 1'b0;
      last = 16'h0000;
   end

   // Reload the stall count at each strobe fall, then count it down
   always @(posedge clk_sys) begin
      strobe_d <= ~(bus.rd_n & bus.wr_n);
      if (~(bus.rd_n & bus.wr_n) && !strobe_d) left <= stall;
      else if (left != 8'h00) left <= left - 8'h01;
      if (!bus.rd_n) last <= bus.addr[15:0] ^ 16'h5a5a;
   end

   // Not ready held as long as the count runs, with no limit on it
   assign ready_pin = (left == 8'h00);

   // Released data shows the inverse, so a late sample never matches
   always_comb din = !bus.rd_n ? (bus.addr[15:0] ^ 16'h5a5a) : ~last;
endmodule : ddb_mem_model
`default_nettype wire

// ==== deferred_demux_bus_cycle_timing_tb_top.sv ====
/*
  Self-checking bench for the bus sequencer with a slow memory model.
  Assumes one 20 MHz clock and the sequencer's handshake from its notes.
*/
`timescale 1ns/100ps
`default_nettype none
module deferred_demux_bus_cycle_timing_tb_top
   import ddb_pkg::*;
;
   // ----------------------------------------------------------------------
   // Signals, design and memory
   // ----------------------------------------------------------------------
   logic              clk_sys = 1'b0;
   logic rst, req_valid, ready_pin, req_ready, rdata_valid, clock_output, defer_active;
   logic [7:0]        cfg1, stall;
   logic [11:0]       bus_region_config;
   logic [DATA_W-1:0] din, rdata;
   ddb_req_t          req;
   ddb_bus_t          bus;
   int                err_total, check_count, seed;
   logic              have_prev, prev_wr;
   logic [2:0]        prev_rg;

   ddb_seq u_dut (.clk_sys(clk_sys), .rst(rst), .chip_config_byte_one(cfg1),
      .bus_region_config(bus_region_config), .req_valid(req_valid), .req(req),
      .ready_pin(ready_pin), .din(din), .req_ready(req_ready), .rdata(rdata),
      .rdata_valid(rdata_valid), .bus(bus), .clock_output(clock_output),
      .defer_active(defer_active));
   ddb_mem_model u_mem (.clk_sys(clk_sys), .bus(bus), .stall(stall), .ready_pin(ready_pin), .din(din));

   always #25 clk_sys = ~clk_sys;

   // Comparisons and verdict
   task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         err_total++;
         $display("unexpected value at %0t: got %h want %h", $time, got, exp);
      end
   endtask : chk_val

   task automatic chk_cnt(input int got, input int exp);
      check_count++;
      if (got != exp) begin
         err_total++;
         $display("unexpected count at %0t: got %0d want %0d", $time, got, exp);
      end
   endtask : chk_cnt

   task automatic end_of_test;
      $display("checks %0d errors %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : end_of_test

   // One bus cycle; n counts clocks from first bus activity to done
   task automatic run_cycle(input logic wr, input logic [2:0] rg, input logic [7:0] st);
      int n, dfr, lo, ale_at, g, ws, al;
      logic exp_d, hb, ft, co_prev;
      logic [ADDR_W-1:0] a;
      logic [DATA_W-1:0] wd;
      n = 0; dfr = 0; lo = 0; ale_at = 0; al = 0; co_prev = 1'b0;
      a = 20'($random(seed));
      wd = 16'($random(seed));
      hb = 1'($random(seed));
      ft = 1'($random(seed));
      @(posedge clk_sys);
      ws = int'(bus_region_config[2*rg +: 2]);
      exp_d = cfg1[5] && have_prev && (rg != prev_rg || (wr && !prev_wr));
      stall <= st;
      req <= '{write: wr, region: rg, addr: a, wdata: wd, high_byte: hb, fetch: ft};
      req_valid <= 1'b1;
      for (g = 0; g < 300 && req_ready !== 1'b1; g++) begin
         @(posedge clk_sys);
         #1;
         // Bus clock toggles every core period, so its period is one state
         if (g > 0) chk_val(clock_output, !co_prev);
         co_prev = clock_output;
         if (bus.ale === 1'b1) al++;
         if (n > 0 || bus.ale === 1'b1 || defer_active === 1'b1) n++;
         if (bus.ale === 1'b1 && ale_at == 0) ale_at = n;
         if (defer_active === 1'b1) begin
            dfr++;
            chk_val(bus.rd_n & bus.wr_n, 1);
            chk_val({bus.addr, bus.region_select_n}, {a, 6'(~(6'h01 << rg))});
         end
         if ((wr ? bus.wr_n : bus.rd_n) === 1'b0) begin
            lo++;
            chk_val(bus.region_select_n, 6'(~(6'h01 << rg)));
            chk_val({bus.addr, bus.high_byte_enable_n, bus.fetch_indicator}, {a, !hb, ft});
            if (wr) chk_val({bus.dout_oe, bus.dout}, {1'b1, wd});
         end
      end
      chk_val(req_ready, 1);
      chk_cnt(al, 1);
      chk_cnt(dfr, exp_d ? 2 : 0);
      chk_cnt(ale_at, exp_d ? 3 : 1);
      if (st == 8'h00) begin
         chk_cnt(n, 5 + (exp_d ? 2 : 0) + 2 * ws);
         chk_cnt(lo, 2 + 2 * ws);
      end else begin
         chk_cnt(int'(lo > 2 + 2 * ws && lo % 2 == 0), 1);
      end
      if (!wr) chk_val({rdata_valid, rdata}, {1'b1, a[15:0] ^ 16'h5a5a});
      else chk_val(rdata_valid, 0);
      have_prev = 1'b1;
      prev_rg = rg;
      prev_wr = wr;
      @(posedge clk_sys);
      req_valid <= 1'b0;
   endtask : run_cycle

   // ----------------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------------
   logic [3:0] plan [8] = '{4'h1, 4'h8 | 4'h2, 4'h2, 4'ha, 4'hb, 4'hb, 4'h4, 4'hc};

   initial begin
      seed = 32'h705d;
      rst = 1'b1; cfg1 = 8'h10; stall = 8'h00;
      bus_region_config = 12'h000; req_valid = 1'b0; req = '0;
      err_total = 0; check_count = 0; have_prev = 1'b0; prev_wr = 1'b0; prev_rg = 3'h0;
      repeat (20) @(posedge clk_sys);
      rst <= 1'b0;
      // Region changes and turnarounds with deferral still off
      run_cycle(1'b0, 3'h1, 8'h00);
      run_cycle(1'b1, 3'h2, 8'h00);
      cfg1 <= 8'h20;
      // Table: write flag in bit 3, region below; covers both causes together
      foreach (plan[i]) run_cycle(plan[i][3], plan[i][2:0], 8'h00);
      // Deepest programmed waits together with a deferral
      bus_region_config <= 12'hfff;
      run_cycle(1'b0, 3'h5, 8'h00);
      run_cycle(1'b1, 3'h0, 8'h00);
      // Memory holds ready low well past the programmed waits
      bus_region_config <= 12'h924;
      run_cycle(1'b0, 3'h1, 8'h09);
      run_cycle(1'b1, 3'h1, 8'h0c);
      repeat (30) begin
         bus_region_config <= 12'($random(seed));
         cfg1 <= {2'b00, 1'($random(seed)), 5'h00};
         run_cycle(1'($random(seed)), 3'($unsigned($random(seed)) % 6), 8'h00);
      end
      end_of_test;
   end

   // Watchdog, far beyond the several hundred clocks the sequence needs
   initial begin
      #(50 * 20000);
      err_total++;
      $display("unexpected hang at %0t: sequence did not finish", $time);
      end_of_test;
   end
endmodule : deferred_demux_bus_cycle_timing_tb_top
`default_nettype wire
